// ==== design/fault_history_defines.vh ====
// Sub-index map, field layout, reset values, summary bits and fault code table of the fault history stack.
`ifndef FAULT_HISTORY_DEFINES_VH
`define FAULT_HISTORY_DEFINES_VH

// Sub-index positions of the history object.
`define SUB_COUNT          8'h00
`define SUB_SLOT_FIRST     8'h01
`define SUB_SLOT_LAST      8'h08

// Depth of the history and saturation value of the count.
`define HISTORY_DEPTH      8
`define COUNT_MAX          8'h08

// Reset values.
`define COUNT_RESET        8'h00
`define SLOT_RESET         32'h0000_0000
`define SUMMARY_RESET      8'h00

// Entry field positions.
`define CAUSE_MSB          31
`define CAUSE_LSB          24
`define CATEGORY_MSB       23
`define CATEGORY_LSB       16
`define CODE_MSB           15
`define CODE_LSB           0

// Error summary bit positions; the spare bit always reads zero.
`define SUM_OVERALL_BIT    0
`define SUM_AMPERAGE_BIT   1
`define SUM_SUPPLY_BIT     2
`define SUM_TEMP_BIT       3
`define SUM_LINK_BIT       4
`define SUM_DRIVE_BIT      5
`define SUM_SPARE_BIT      6
`define SUM_VENDOR_BIT     7

// Abort answer for a read of an entry while the history is empty.
`define ABORT_EMPTY        32'h0800_0024

// Standard fault codes.
`define CODE_GENERAL       16'h1000
`define CODE_OUT_CURRENT   16'h2300
`define CODE_IN_VOLTAGE    16'h3100
`define CODE_CTRL_TEMP     16'h4200
`define CODE_WATCHDOG      16'h6010
`define CODE_SOFTWARE      16'h6100
`define CODE_RATED_UNSET   16'h6320
`define CODE_BLOCKED       16'h7121
`define CODE_SENSOR        16'h7305
`define CODE_NV_STORE      16'h7600
`define CODE_BUS_MONITOR   16'h8000
`define CODE_GUARDING      16'h8130
`define CODE_PDO_SLOW      16'h8200
`define CODE_PDO_LENGTH    16'h8210
`define CODE_PDO_LONG      16'h8220
`define CODE_FOLLOWING     16'h8611
`define CODE_LIMIT         16'h8612
`define CODE_BUS_STATE     16'h9000

`endif

// ==== design/fault_code_map.v ====
// Maps a fault cause index to its standard 16-bit fault code.
`timescale 1ns/1ps
`default_nettype none
`include "fault_history_defines.vh"

module fault_code_map (
  // Cause in, code out
  input  wire [7:0]  cause_i,
  output reg  [15:0] code_o
);

  always @* begin
    case (cause_i)
      8'h00:                      code_o = `CODE_WATCHDOG;
      8'h01, 8'h03:               code_o = `CODE_IN_VOLTAGE;
      8'h02, 8'h18, 8'h1A:        code_o = `CODE_OUT_CURRENT;
      8'h04, 8'h1B:               code_o = `CODE_BUS_MONITOR;
      8'h06:                      code_o = `CODE_GUARDING;
      8'h07, 8'h08, 8'h09, 8'h12: code_o = `CODE_SENSOR;
      8'h0A, 8'h0B:               code_o = `CODE_LIMIT;
      8'h0C:                      code_o = `CODE_CTRL_TEMP;
      8'h0D:                      code_o = `CODE_FOLLOWING;
      8'h0E, 8'h10, 8'h15:        code_o = `CODE_NV_STORE;
      8'h0F:                      code_o = `CODE_BLOCKED;
      8'h11:                      code_o = `CODE_PDO_SLOW;
      8'h13:                      code_o = `CODE_PDO_LENGTH;
      8'h14:                      code_o = `CODE_PDO_LONG;
      8'h16:                      code_o = `CODE_RATED_UNSET;
      8'h19:                      code_o = `CODE_SOFTWARE;
      8'h1C:                      code_o = `CODE_BUS_STATE;
      default:                    code_o = `CODE_GENERAL;
    endcase
  end

endmodule // fault_code_map
`default_nettype wire

// ==== design/fault_entry_slot.v ====
// One storage position of the fault history stack.
`timescale 1ns/1ps
`default_nettype none
`include "fault_history_defines.vh"

module fault_entry_slot #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             core_clk_i,
  input  wire             srst_i,
  // Control; a shift beats a clear in the same cycle
  input  wire             shift_i,
  input  wire             clear_i,
  input  wire [WIDTH-1:0] d_i,
  // Stored entry
  output reg  [WIDTH-1:0] q_o
);

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      q_o <= `SLOT_RESET;
    end else if (shift_i) begin
      q_o <= d_i;
    end else if (clear_i) begin
      q_o <= `SLOT_RESET;
    end
  end

endmodule // fault_entry_slot
`default_nettype wire

// ==== design/fault_history_stack.v ====
// Fault history stack: newest-first fault entries, fault count and error summary byte.
`timescale 1ns/1ps
`default_nettype none
`include "fault_history_defines.vh"

// Operation
// - Hold up to eight 32-bit entries.
// - New fault entry goes into slot one.
// - Older entries shift deeper; deepest is dropped.
// - Fault count readable at sub-index zero.
// - Empty history refuses entry reads, abort 08000024.
// - Writing zero to count restarts counting.
// - Entry packs cause, category and code.
// - Power and supervision cause indices.
// - Fieldbus related cause indices.
// - Motor and sensor cause indices.
// - Motion limit cause indices.
// - Housekeeping cause indices.
// - Category byte copies the error summary.
// - Summary bits follow their fault conditions.
// - Fault code field uses standard codes.
module fault_history_stack #(
  parameter        DEPTH             = `HISTORY_DEPTH,
  // Abort answers not fixed by the history object itself; values are arbitrary.
  parameter [31:0] ABORT_READ_ONLY   = 32'h0000_0001,
  parameter [31:0] ABORT_BAD_VALUE   = 32'h0000_0002,
  parameter [31:0] ABORT_NO_SUBINDEX = 32'h0000_0003
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        srst_i,

  // Fault event from the detection logic
  input  wire        fault_evt_i,
  input  wire [7:0]  fault_cause_i,

  // Fault condition levels feeding the error summary
  input  wire        overall_fault_flag_i,
  input  wire        amperage_fault_flag_i,
  input  wire        supply_level_fault_flag_i,
  input  wire        temperature_fault_flag_i,
  input  wire        link_fault_flag_i,
  input  wire        drive_behavior_fault_flag_i,
  input  wire        vendor_fault_flag_i,

  // Object dictionary access from the fieldbus side
  input  wire        od_req_i,
  input  wire        od_wr_i,
  input  wire [7:0]  od_sub_i,
  input  wire [31:0] od_wdata_i,

  // Object dictionary answer
  output wire        od_ack_o,
  output wire        od_abort_o,
  output wire [31:0] od_abort_code_o,
  output wire [31:0] od_rdata_o,

  // Live state
  output wire [7:0]  fault_history_count_o,
  output wire [7:0]  error_summary_o
);

  // Answer state machine, one-hot.
  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_ANSWER = 2'b10;

  reg  [1:0]        state_ff;
  reg  [1:0]        nxt_state;

  reg  [7:0]        count_ff;
  reg  [7:0]        nxt_count;
  reg  [7:0]        summary_ff;
  reg  [7:0]        nxt_summary;

  reg               ack_ff;
  reg               nxt_ack;
  reg               abort_ff;
  reg               nxt_abort;
  reg  [31:0]       abort_code_ff;
  reg  [31:0]       nxt_abort_code;
  reg  [31:0]       rdata_ff;
  reg  [31:0]       nxt_rdata;

  reg               history_clear;
  reg  [31:0]       read_entry;
  reg               req_refused;
  reg  [31:0]       req_refuse_code;
  reg  [31:0]       req_data;

  wire [15:0]       mapped_code;
  wire [31:0]       new_entry;
  wire [32*DEPTH-1:0] slot_q;
  wire [32*DEPTH-1:0] slot_d;
  wire              is_count_sub;
  wire              is_slot_sub;
  wire [7:0]        slot_index;
  wire [DEPTH-1:0]  slot_shift;
  wire              history_empty;
  wire              history_full;

  integer           k;

  // ---------------------------------------------------------------------
  // Error summary byte.
  // ---------------------------------------------------------------------

  always @* begin
    nxt_summary                    = `SUMMARY_RESET;
    nxt_summary[`SUM_OVERALL_BIT]  = overall_fault_flag_i;
    nxt_summary[`SUM_AMPERAGE_BIT] = amperage_fault_flag_i;
    nxt_summary[`SUM_SUPPLY_BIT]   = supply_level_fault_flag_i;
    nxt_summary[`SUM_TEMP_BIT]     = temperature_fault_flag_i;
    nxt_summary[`SUM_LINK_BIT]     = link_fault_flag_i;
    nxt_summary[`SUM_DRIVE_BIT]    = drive_behavior_fault_flag_i;
    nxt_summary[`SUM_SPARE_BIT]    = 1'b0;
    nxt_summary[`SUM_VENDOR_BIT]   = vendor_fault_flag_i;
  end

  // Bits carry no memory: once a condition goes away its bit drops with it.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      summary_ff <= `SUMMARY_RESET;
    end else begin
      summary_ff <= nxt_summary;
    end
  end

  // ---------------------------------------------------------------------
  // New entry assembly.
  // ---------------------------------------------------------------------

  fault_code_map u_code_map (
    .cause_i (fault_cause_i),
    .code_o  (mapped_code)
  );

  // The category uses the summary as it stands with this fault's own flag,
  // so a fault that raises its flag in the same cycle is classed correctly.
  // entry field packing
  assign new_entry = {fault_cause_i, nxt_summary, mapped_code};

  // ---------------------------------------------------------------------
  // History storage.
  // ---------------------------------------------------------------------

  assign slot_d[31:0] = new_entry;

  assign slot_d[32*DEPTH-1:32] = slot_q[32*(DEPTH-1)-1:0];

  genvar g;

  // A fault in the clearing cycle survives in slot one; deeper slots empty.
  // per-slot shift enables
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gen_shift
      if (g == 0) begin : gen_top
        assign slot_shift[g] = fault_evt_i;
      end else begin : gen_deep
        assign slot_shift[g] = fault_evt_i && !history_clear;
      end
    end
  endgenerate

  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gen_slot
      fault_entry_slot #(
        .WIDTH (32)
      ) u_slot (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .shift_i    (slot_shift[g]),
        .clear_i    (history_clear),
        .d_i        (slot_d[32*g+31:32*g]),
        .q_o        (slot_q[32*g+31:32*g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Request decode.
  // ---------------------------------------------------------------------

  assign is_count_sub = (od_sub_i == `SUB_COUNT);
  assign is_slot_sub  = (od_sub_i >= `SUB_SLOT_FIRST) &&
                        (od_sub_i <= `SUB_SLOT_LAST);
  assign slot_index   = od_sub_i - `SUB_SLOT_FIRST;

  always @* begin
    history_clear = od_req_i && od_wr_i && is_count_sub &&
                    (od_wdata_i == 32'h0000_0000);
  end

  always @* begin
    read_entry = `SLOT_RESET;
    for (k = 0; k < DEPTH; k = k + 1) begin
      if (slot_index == k[7:0]) begin
        read_entry = slot_q[32*k +: 32];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Fault count.
  // ---------------------------------------------------------------------

  // Empty and full views of the count; the answer path uses the empty view
  // to refuse entry reads, the count path the full view to saturate.
  assign history_empty = (count_ff == `COUNT_RESET);
  assign history_full  = (count_ff >= `COUNT_MAX);

  // A fault arriving with the clearing write is counted, not lost.
  // count saturates at eight
  always @* begin
    nxt_count = count_ff;
    if (history_clear) begin
      nxt_count = fault_evt_i ? 8'h01 : `COUNT_RESET;
    end else if (fault_evt_i && !history_full) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      count_ff <= `COUNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ---------------------------------------------------------------------
  // Answer path.
  // ---------------------------------------------------------------------

  // Classification of the request on the bus this cycle. Refused requests
  // leave the history untouched; only the zero write to the count acts.
  always @* begin
    req_refused     = 1'b0;
    req_refuse_code = 32'h0000_0000;
    req_data        = 32'h0000_0000;
    if (od_wr_i) begin
      if (is_count_sub) begin
        if (od_wdata_i != 32'h0000_0000) begin
          req_refused     = 1'b1;
          req_refuse_code = ABORT_BAD_VALUE;
        end
      end else if (is_slot_sub) begin
        req_refused     = 1'b1;
        req_refuse_code = ABORT_READ_ONLY;
      end else begin
        req_refused     = 1'b1;
        req_refuse_code = ABORT_NO_SUBINDEX;
      end
    end else begin
      if (is_count_sub) begin
        req_data = {24'h00_0000, count_ff};
      end else if (is_slot_sub) begin
        if (history_empty) begin
          req_refused     = 1'b1;
          req_refuse_code = `ABORT_EMPTY;
        end else begin
          req_data = read_entry;
        end
      end else begin
        req_refused     = 1'b1;
        req_refuse_code = ABORT_NO_SUBINDEX;
      end
    end
  end

  // Each request is answered exactly one cycle later, back to back if need
  // be. Data and abort fields hold their last value between answers.
  always @* begin
    nxt_state      = state_ff;
    nxt_ack        = 1'b0;
    nxt_abort      = abort_ff;
    nxt_abort_code = abort_code_ff;
    nxt_rdata      = rdata_ff;
    case (state_ff)
      ST_IDLE: begin
        if (od_req_i) begin
          nxt_state      = ST_ANSWER;
          nxt_ack        = 1'b1;
          nxt_abort      = req_refused;
          nxt_abort_code = req_refuse_code;
          nxt_rdata      = req_data;
        end
      end
      ST_ANSWER: begin
        if (od_req_i) begin
          nxt_ack        = 1'b1;
          nxt_abort      = req_refused;
          nxt_abort_code = req_refuse_code;
          nxt_rdata      = req_data;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff      <= ST_IDLE;
      ack_ff        <= 1'b0;
      abort_ff      <= 1'b0;
      abort_code_ff <= 32'h0000_0000;
      rdata_ff      <= 32'h0000_0000;
    end else begin
      state_ff      <= nxt_state;
      ack_ff        <= nxt_ack;
      abort_ff      <= nxt_abort;
      abort_code_ff <= nxt_abort_code;
      rdata_ff      <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all straight from flip-flops.
  // ---------------------------------------------------------------------

  assign od_ack_o              = ack_ff;
  assign od_abort_o            = abort_ff;
  assign od_abort_code_o       = abort_code_ff;
  assign od_rdata_o            = rdata_ff;
  assign fault_history_count_o = count_ff;
  assign error_summary_o       = summary_ff;

endmodule // fault_history_stack
`default_nettype wire

// ==== tb/fault_history_stack_sva.sv ====
// Concurrent checks on the ports of the fault history stack.
`timescale 1ns/1ps
`default_nettype none
`include "fault_history_defines.vh"
module fault_history_stack_chk #(
  parameter DEPTH = 8
) (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  // Fault side
  input wire logic        fault_evt_i,
  input wire logic [7:0]  fault_cause_i,
  input wire logic        amperage_fault_flag_i,
  input wire logic        vendor_fault_flag_i,
  // Access side
  input wire logic        od_req_i,
  input wire logic        od_wr_i,
  input wire logic [7:0]  od_sub_i,
  input wire logic [31:0] od_wdata_i,
  input wire logic        od_ack_o,
  input wire logic        od_abort_o,
  input wire logic [31:0] od_abort_code_o,
  input wire logic [31:0] od_rdata_o,
  input wire logic [7:0]  fault_history_count_o,
  input wire logic [7:0]  error_summary_o
);
  localparam logic [7:0] FULL = DEPTH;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  wire logic clr_w = od_req_i && od_wr_i && od_sub_i == `SUB_COUNT && od_wdata_i == 32'h0;
  wire logic rd_w  = od_req_i && !od_wr_i && !fault_evt_i;
  sequence push_s;
    fault_evt_i && !clr_w;
  endsequence
  sequence quiet_s;
    !fault_evt_i && !clr_w;
  endsequence
  sequence read_top_s;
    rd_w && od_sub_i == `SUB_SLOT_FIRST;
  endsequence
  ack_after_req_a: assert property (od_req_i |=> od_ack_o)
    else $error("ack missing after request");
  no_stray_ack_a: assert property (!od_req_i |=> !od_ack_o)
    else $error("ack without request");
  count_step_a: assert property (push_s and (fault_history_count_o < FULL) |=>
    fault_history_count_o == $past(fault_history_count_o) + 8'h01)
    else $error("count did not step on fault");
  count_hold_a: assert property (push_s and (fault_history_count_o == FULL) |=>
    fault_history_count_o == FULL)
    else $error("count left its ceiling");
  count_clear_a: assert property (clr_w && !fault_evt_i |=> fault_history_count_o == 8'h00)
    else $error("count not cleared");
  empty_abort_a: assert property (rd_w && od_sub_i >= `SUB_SLOT_FIRST &&
    od_sub_i <= `SUB_SLOT_LAST && fault_history_count_o == 8'h00 |=>
    od_abort_o && od_abort_code_o == `ABORT_EMPTY)
    else $error("empty read not refused");
  bad_write_a: assert property (od_req_i && od_wr_i && od_sub_i == `SUB_COUNT &&
    !clr_w && !fault_evt_i |=> od_abort_o && $stable(fault_history_count_o))
    else $error("nonzero count write accepted");
  count_read_a: assert property (rd_w && od_sub_i == `SUB_COUNT |=>
    od_rdata_o == {24'h0, $past(fault_history_count_o)})
    else $error("count read wrong");
  top_cause_a: assert property (push_s ##1 quiet_s ##1 read_top_s |=>
    od_rdata_o[31:24] == $past(fault_cause_i, 3))
    else $error("newest cause wrong");
  code_map_a: assert property ((push_s and fault_cause_i == 8'h02) ##1 quiet_s
    ##1 read_top_s |=> od_rdata_o[15:0] == 16'h2300)
    else $error("fault code wrong");
  summary_a: assert property (!$past(srst_i) |-> error_summary_o[6] == 1'b0 &&
    error_summary_o[1] == $past(amperage_fault_flag_i) &&
    error_summary_o[7] == $past(vendor_fault_flag_i))
    else $error("summary byte wrong");
endmodule // fault_history_stack_chk
bind fault_history_stack fault_history_stack_chk #(.DEPTH(DEPTH)) chk_i (.*);
`default_nettype wire

// ==== tb/od_master.sv ====
// Fieldbus master model issuing dictionary accesses to the stack.
`timescale 1ns/1ps
`default_nettype none
module od_master (
  // Clock
  input  wire logic        core_clk_i,
  // Request
  output logic             od_req_o,
  output logic             od_wr_o,
  output logic [7:0]       od_sub_o,
  output logic [31:0]      od_wdata_o,
  // Answer
  input  wire logic        od_ack_i,
  input  wire logic        od_abort_i,
  input  wire logic [31:0] od_abort_code_i,
  input  wire logic [31:0] od_rdata_i
);
  initial begin
    od_req_o = 1'b0;
    od_wr_o = 1'b0;
    od_sub_o = 8'hFF;
    od_wdata_o = 32'hFFFF_FFFF;
  end
  task automatic xfer(input logic wr, input logic [7:0] sub, input logic [31:0] wd,
                      output logic seen, output logic ab, output logic [31:0] code,
                      output logic [31:0] rd);
    int n;
    @(negedge core_clk_i);
    od_req_o = 1'b1;
    od_wr_o = wr;
    od_sub_o = sub;
    od_wdata_o = wd;
    @(negedge core_clk_i);
    // Released lines carry the inverse so stale values cannot pass.
    od_req_o = 1'b0;
    od_wr_o = ~wr;
    od_sub_o = ~sub;
    od_wdata_o = ~wd;
    n = 0;
    while (od_ack_i !== 1'b1 && n < 4) begin
      @(negedge core_clk_i);
      n++;
    end
    seen = od_ack_i;
    ab = od_abort_i;
    code = od_abort_code_i;
    rd = od_rdata_i;
  endtask
endmodule // od_master
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench of the fault history stack.
`timescale 1ns/1ps
`default_nettype none
`include "fault_history_defines.vh"
module tb;
  logic        core_clk_i = 1'b0;
  logic        srst = 1'b1;
  logic        fault_evt = 1'b0;
  logic [7:0]  fault_cause = 8'h00;
  logic [7:0]  flg = 8'h00;
  logic        req, wr, ack, ab;
  logic [7:0]  sub;
  logic [31:0] wd, code, rd;
  logic [7:0]  cnt, esum;
  int          mismatches = 0;
  int          comparisons = 0;
  int          i;
  // Cause, flag byte, expected entry.
  logic [47:0] rows [10] = '{48'h00_01_0001_6010, 48'h02_02_0202_2300, 48'h03_04_0304_3100,
    48'h06_10_0610_8130, 48'h07_20_0720_7305, 48'h0A_80_0A80_8612, 48'h0C_08_0C08_4200,
    48'h0D_00_0D00_8611, 48'h0E_00_0E00_7600, 48'h1C_81_1C81_9000};
  always #20 core_clk_i = ~core_clk_i;
  fault_history_stack DUT (.core_clk_i(core_clk_i), .srst_i(srst), .fault_evt_i(fault_evt),
    .fault_cause_i(fault_cause), .overall_fault_flag_i(flg[0]), .amperage_fault_flag_i(flg[1]),
    .supply_level_fault_flag_i(flg[2]), .temperature_fault_flag_i(flg[3]),
    .link_fault_flag_i(flg[4]), .drive_behavior_fault_flag_i(flg[5]),
    .vendor_fault_flag_i(flg[7]), .od_req_i(req), .od_wr_i(wr), .od_sub_i(sub),
    .od_wdata_i(wd), .od_ack_o(ack), .od_abort_o(ab), .od_abort_code_o(code),
    .od_rdata_o(rd), .fault_history_count_o(cnt), .error_summary_o(esum));
  od_master m (.core_clk_i(core_clk_i), .od_req_o(req), .od_wr_o(wr), .od_sub_o(sub),
    .od_wdata_o(wd), .od_ack_i(ack), .od_abort_i(ab), .od_abort_code_i(code), .od_rdata_i(rd));
  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // An expected abort with a zero code leaves the code unchecked.
  task automatic acc(input logic w, input logic [7:0] s, input logic [31:0] d,
                     input logic eab, input logic [31:0] edat);
    logic seen, gab;
    logic [31:0] gcode, grd;
    m.xfer(w, s, d, seen, gab, gcode, grd);
    chk("ack", 32'h1, {31'h0, seen});
    chk("abort", {31'h0, eab}, {31'h0, gab});
    if (eab && edat != 32'h0) chk("abort_code", edat, gcode);
    if (!eab && !w) chk("rdata", edat, grd);
  endtask
  task automatic push(input logic [7:0] cause, input logic [7:0] flags);
    @(negedge core_clk_i);
    fault_evt = 1'b1;
    fault_cause = cause;
    flg = flags;
    @(negedge core_clk_i);
    fault_evt = 1'b0;
    fault_cause = ~cause;
  endtask
  initial begin
    #(40 * 3000);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(negedge core_clk_i);
    srst = 1'b0;
    acc(1'b0, `SUB_COUNT, 32'h0, 1'b0, 32'h0);
    acc(1'b0, `SUB_SLOT_FIRST, 32'h0, 1'b1, `ABORT_EMPTY);
    acc(1'b0, `SUB_SLOT_LAST, 32'h0, 1'b1, `ABORT_EMPTY);
    for (i = 0; i < 10; i++) begin
      push(rows[i][47:40], rows[i][39:32]);
      chk("count_o", (i < 8) ? 32'(i + 1) : 32'h8, {24'h0, cnt});
      chk("summary", {24'h0, rows[i][39:32]}, {24'h0, esum});
      acc(1'b0, `SUB_SLOT_FIRST, 32'h0, 1'b0, rows[i][31:0]);
      acc(1'b0, `SUB_COUNT, 32'h0, 1'b0, (i < 8) ? 32'(i + 1) : 32'h8);
    end
    for (i = 1; i <= 8; i++) acc(1'b0, 8'(i), 32'h0, 1'b0, rows[10 - i][31:0]);
    acc(1'b1, 8'h03, 32'h1, 1'b1, 32'h1);
    acc(1'b1, `SUB_COUNT, 32'h5, 1'b1, 32'h2);
    acc(1'b0, `SUB_COUNT, 32'h0, 1'b0, 32'h8);
    acc(1'b0, 8'h09, 32'h0, 1'b1, 32'h3);
    acc(1'b1, `SUB_COUNT, 32'h0, 1'b0, 32'h0);
    acc(1'b0, `SUB_COUNT, 32'h0, 1'b0, 32'h0);
    acc(1'b0, `SUB_SLOT_FIRST, 32'h0, 1'b1, `ABORT_EMPTY);
    push(8'h02, 8'h02);
    acc(1'b0, `SUB_COUNT, 32'h0, 1'b0, 32'h1);
    acc(1'b0, `SUB_SLOT_FIRST, 32'h0, 1'b0, 32'h0202_2300);
    flg = 8'h00;
    @(negedge core_clk_i);
    chk("summary", 32'h0, {24'h0, esum});
    srst = 1'b1;
    repeat (2) @(negedge core_clk_i);
    srst = 1'b0;
    acc(1'b0, `SUB_COUNT, 32'h0, 1'b0, 32'h0);
    chk("count_o", 32'h0, {24'h0, cnt});
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
